// >>> uld_pkg.sv
// Shared constants of the serial-linked DMA channel.
// Assumes a 32-bit Avalon-MM bus addressed in bytes.
package uld_pkg;

    // Register byte offsets
    localparam logic [5:0] OFF_MEM_CTRL  = 6'h00; // Memory select, auto-echo
    localparam logic [5:0] OFF_IRQ_EN    = 6'h04; // Serial irq/link enables
    localparam logic [5:0] OFF_TX_CTRL   = 6'h08; // Tx DMA enable
    localparam logic [5:0] OFF_PTR       = 6'h0c; // Pointer pair
    localparam logic [5:0] OFF_COUNT     = 6'h10; // Count high:low
    localparam logic [5:0] OFF_STATUS    = 6'h14; // Sticky events, busy
    localparam logic [5:0] OFF_EVT_CLR   = 6'h18; // Write-only event clear
    localparam logic [5:0] OFF_EVT_EN    = 6'h1c; // Event irq enable

    // Bit positions
    localparam int BIT_MEM_EXT    = 0;  // Memory-select bit
    localparam int BIT_ECHO       = 1;  // Auto-echo bit
    localparam int BIT_RX_IRQ_EN  = 0;  // Rx irq enable
    localparam int BIT_RX_LINK    = 1;  // Rx link
    localparam int BIT_TX_IRQ_EN  = 2;  // Tx irq enable
    localparam int BIT_TX_DMA     = 0;  // Tx DMA run
    localparam int EVT_RX         = 0;  // Rx done
    localparam int EVT_TX         = 1;  // Tx done
    localparam int BIT_BUSY       = 2;  // Status busy bit

    // Widths and reset values
    localparam int EVT_W          = 2;
    localparam logic [15:0] PTR_RST   = 16'h0000;
    localparam logic [15:0] CNT_RST   = 16'h0000;
    localparam logic [15:0] CNT_END   = 16'hffff; // Count after passing zero
    localparam logic [2:0]  UIE_RST   = 3'h0;
    localparam logic [EVT_W-1:0] EVT_RST = 2'h0;

    // Memory port phases
    typedef enum logic [1:0] {
        MP_IDLE   = 2'b00,
        MP_STROBE = 2'b01,
        MP_DATA   = 2'b10,
        MP_DONE   = 2'b11
    } uld_mp_type;

    // Channel sequencer states
    typedef enum logic [1:0] {
        CH_IDLE   = 2'b00,
        CH_RX_MEM = 2'b01,
        CH_TX_MEM = 2'b10,
        CH_SETTLE = 2'b11
    } uld_ch_type;

endpackage : uld_pkg

// >>> uld_mem_port.sv
// One-byte access to internal or external memory.
// Assumes synchronous memories, one cycle read latency.
`timescale 1ns/1ps
module uld_mem_port (
    input  wire logic        mclk,        // Clock
    input  wire logic        resetn,      // Sync reset
    input  wire logic        req,         // Start access
    input  wire logic        req_we,      // 1 write, 0 read
    input  wire logic        sel_ext,     // 1 external
    input  wire logic [15:0] addr,        // Byte address
    input  wire logic [7:0]  wdata,       // Write byte
    output logic             done,        // Done pulse
    output logic      [7:0]  rdata,       // Read byte
    output logic             int_en,      // Int strobe
    output logic             int_we,      // Int write
    output logic      [7:0]  int_addr,    // Int address
    output logic      [7:0]  int_wdata,   // Int data
    input  wire logic [7:0]  int_rdata,   // Int read
    output logic             ext_dm_n,    // Ext strobe, low
    output logic             ext_we,      // Ext write
    output logic      [15:0] ext_addr,    // Ext address
    output logic      [7:0]  ext_wdata,   // Ext data
    input  wire logic [7:0]  ext_rdata    // Ext read
);
    typedef struct packed {
        uld_pkg::uld_mp_type ph;
        logic        ext;
        logic        int_en;
        logic        int_we;
        logic [7:0]  int_addr;
        logic        dm_n;
        logic        ext_we;
        logic [15:0] ext_addr;
        logic [7:0]  wd;
        logic [7:0]  rd;
    } uld_mp_state_type;

    uld_mp_state_type s_r, s_nxt;

    // One strobe cycle, one data cycle, then done
    always_comb begin
        s_nxt        = s_r;
        s_nxt.int_en = 1'b0;
        s_nxt.dm_n   = 1'b1;
        unique case (s_r.ph)
            uld_pkg::MP_IDLE: begin
                if (req) begin
                    s_nxt.ph  = uld_pkg::MP_STROBE;
                    s_nxt.ext = sel_ext;
                    s_nxt.wd  = wdata;
                    // [RULE4] only data-memory space reached
                    s_nxt.dm_n     = ~sel_ext;
                    s_nxt.ext_we   = req_we;
                    s_nxt.ext_addr = addr;
                    // [RULE7] internal uses the low pointer byte
                    s_nxt.int_en   = ~sel_ext;
                    s_nxt.int_we   = req_we;
                    s_nxt.int_addr = addr[7:0];
                end
            end
            uld_pkg::MP_STROBE: s_nxt.ph = uld_pkg::MP_DATA;
            uld_pkg::MP_DATA: begin
                s_nxt.ph = uld_pkg::MP_DONE;
                s_nxt.rd = s_r.ext ? ext_rdata : int_rdata;
            end
            uld_pkg::MP_DONE:   s_nxt.ph = uld_pkg::MP_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            s_r      <= '0;
            s_r.dm_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign done      = (s_r.ph == uld_pkg::MP_DONE);
    assign rdata     = s_r.rd;
    assign int_en    = s_r.int_en;
    assign int_we    = s_r.int_we;
    assign int_addr  = s_r.int_addr;
    assign int_wdata = s_r.wd;
    assign ext_dm_n  = s_r.dm_n;
    assign ext_we    = s_r.ext_we;
    assign ext_addr  = s_r.ext_addr;
    assign ext_wdata = s_r.wd;

endmodule : uld_mem_port

// >>> uld_evt_ctrl.sv
// Sticky events, enable mask, irq and serial vectors.
// Assumes inputs come from logic on mclk.
`timescale 1ns/1ps
module uld_evt_ctrl (
    input  wire logic        mclk,      // Clock
    input  wire logic        resetn,    // Sync reset
    input  wire logic [1:0]  evt_set,   // Event pulses
    input  wire logic        clr_we,    // Clear write
    input  wire logic [1:0]  clr_data,  // Clear mask
    input  wire logic        en_we,     // Mask write
    input  wire logic [1:0]  en_data,   // New mask
    input  wire logic [1:0]  vec_en,    // Vector enables
    output logic      [1:0]  status,    // Sticky events
    output logic      [1:0]  enable,    // Mask
    output logic             irq,       // Event irq
    output logic      [1:0]  svc_irq    // Rx/tx vectors
);
    typedef struct packed {
        logic [1:0] st;
        logic [1:0] en;
        logic       irq;
        logic [1:0] svc;
    } uld_evt_state_type;

    uld_evt_state_type s_r, s_nxt;

    // Set wins over a clear in the same cycle
    always_comb begin
        s_nxt    = s_r;
        s_nxt.st = (s_r.st & ~(clr_we ? clr_data : 2'h0)) | evt_set;
        if (en_we) begin
            s_nxt.en = en_data;
        end
        s_nxt.irq = |(s_nxt.st & s_nxt.en);
        // [RULE1] completion through the serial vectors
        s_nxt.svc = s_nxt.st & vec_en;
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign status  = s_r.st;
    assign enable  = s_r.en;
    assign irq     = s_r.irq;
    assign svc_irq = s_r.svc;

endmodule : uld_evt_ctrl

// >>> uld_top.sv
// Serial-linked DMA channel: serial chars to and from memory,
// a byte count ending each run.
// Assumes serial port and memories on mclk;
// registers over Avalon-MM.
//
// Operation
// [RULE1] Completion on serial rx/tx vectors
// [RULE2] Each direction has its own completion
// [RULE3] Select bit picks external or internal
// [RULE4] External access only under data strobe
// [RULE5] External address from the pointer pair
// [RULE6] Count decrements, ends passing zero
// [RULE7] Internal address from pointer low byte
// [RULE8] Rx bytes into either memory
// [RULE9] Tx bytes from either memory
// [RULE10] Auto-echo resends each rx char
// [RULE11] Rx irq plus link starts receive
// [RULE12] Software reloads pointer, count before each
// [RULE13] Software loads count as n minus one
// [RULE14] Transmit DMA bit runs transmit channel
// [RULE15] Pointer advances one per byte
// [RULE16] Serial events trigger each byte
//
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module uld_top (
    input  wire logic        mclk,              // Clock
    input  wire logic        resetn,            // Sync reset
    input  wire logic [5:0]  avs_address,       // Byte address
    input  wire logic        avs_read,          // Read
    input  wire logic        avs_write,         // Write
    input  wire logic [31:0] avs_writedata,     // Write data
    input  wire logic [3:0]  avs_byteenable,    // Byte lanes
    output logic      [31:0] avs_readdata,      // Read data
    output logic             avs_waitrequest,   // Stall
    input  wire logic        rx_char_valid,     // Char in, pulse
    input  wire logic [7:0]  rx_char,           // Char in
    input  wire logic        tx_buf_empty,      // Tx buffer empty
    output logic             tx_load,           // Tx load pulse
    output logic      [7:0]  tx_char,           // Tx char
    output logic             int_en,            // Int strobe
    output logic             int_we,            // Int write
    output logic      [7:0]  int_addr,          // Int address
    output logic      [7:0]  int_wdata,         // Int data
    input  wire logic [7:0]  int_rdata,         // Int read
    output logic             data_memory_select_strobe_n, // Ext strobe
    output logic             ext_we,            // Ext write
    output logic      [15:0] ext_addr,          // Ext address
    output logic      [7:0]  ext_wdata,         // Ext data
    input  wire logic [7:0]  ext_rdata,         // Ext read
    output logic             rx_service_irq,    // Rx vector
    output logic             tx_service_irq,    // Tx vector
    output logic             irq                // Event irq
);
    typedef struct packed {
        logic                 wait_n;    // Bus answer phase
        logic [31:0]          rdata;
        logic                 mem_ext;
        logic                 echo_en;
        logic [2:0]           serial_irq_enable_reg;
        logic                 txdma;
        logic [15:0]          ptr;
        logic [15:0]          cnt;
        logic                 rx_term;
        logic                 tx_term;
        uld_pkg::uld_ch_type  st;
        logic                 rx_pend;
        logic [7:0]           rx_byte;
        logic                 echo_pend;
        logic [7:0]           echo_byte;
        logic                 tx_load;
        logic [7:0]           tx_char;
        logic                 req;
        logic                 req_we;
        logic [1:0]           evt;
    } uld_state_type;

    uld_state_type s_r, s_nxt;

    logic       mp_done;
    logic [7:0] mp_rdata;
    logic [1:0] ev_status;
    logic [1:0] ev_enable;
    logic [1:0] svc;
    logic       bus_req;
    logic       wr_go;
    logic       clr_we;
    logic       en_we;
    logic       rx_run;
    logic       tx_run;

    // Pointer step; internal wraps in low byte
    function automatic logic [15:0] next_ptr(input logic [15:0] p, input logic ext);
        next_ptr = ext ? p + 16'h0001 : {p[15:8], p[7:0] + 8'h01};
    endfunction : next_ptr

    // Byte-lane merge
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : merge16

    assign bus_req = avs_read | avs_write;
    assign wr_go   = avs_write & s_r.wait_n;
    assign clr_we  = wr_go & avs_byteenable[0] & (avs_address == uld_pkg::OFF_EVT_CLR);
    assign en_we   = wr_go & avs_byteenable[0] & (avs_address == uld_pkg::OFF_EVT_EN);

    // [RULE11] receive needs interrupt enable and link
    assign rx_run = s_r.serial_irq_enable_reg[uld_pkg::BIT_RX_IRQ_EN] & s_r.serial_irq_enable_reg[uld_pkg::BIT_RX_LINK] & ~s_r.rx_term;
    // [RULE14] transmit runs on the DMA bit
    assign tx_run = s_r.txdma & ~s_r.tx_term;

    // Bus, capture and sequencing
    always_comb begin
        s_nxt         = s_r;
        s_nxt.tx_load = 1'b0;
        s_nxt.req     = 1'b0;
        s_nxt.evt     = uld_pkg::EVT_RST;

        // One wait cycle per access
        s_nxt.wait_n = bus_req & ~s_r.wait_n;
        if (avs_read & ~s_r.wait_n) begin
            unique case (avs_address)
                uld_pkg::OFF_MEM_CTRL: s_nxt.rdata = {30'h0, s_r.echo_en, s_r.mem_ext};
                uld_pkg::OFF_IRQ_EN:   s_nxt.rdata = {29'h0, s_r.serial_irq_enable_reg};
                uld_pkg::OFF_TX_CTRL:  s_nxt.rdata = {31'h0, s_r.txdma};
                uld_pkg::OFF_PTR:      s_nxt.rdata = {16'h0, s_r.ptr};
                uld_pkg::OFF_COUNT:    s_nxt.rdata = {16'h0, s_r.cnt};
                uld_pkg::OFF_STATUS:   s_nxt.rdata = {29'h0, (s_r.st != uld_pkg::CH_IDLE), ev_status};
                uld_pkg::OFF_EVT_EN:   s_nxt.rdata = {30'h0, ev_enable};
                default:               s_nxt.rdata = 32'h0;
            endcase
        end

        // Writes land with the answer
        if (wr_go && avs_byteenable[0]) begin
            unique case (avs_address)
                uld_pkg::OFF_MEM_CTRL: begin
                    // [RULE3] memory-select bit
                    s_nxt.mem_ext = avs_writedata[uld_pkg::BIT_MEM_EXT];
                    s_nxt.echo_en = avs_writedata[uld_pkg::BIT_ECHO];
                end
                uld_pkg::OFF_IRQ_EN:  s_nxt.serial_irq_enable_reg   = avs_writedata[2:0];
                uld_pkg::OFF_TX_CTRL: s_nxt.txdma = avs_writedata[uld_pkg::BIT_TX_DMA];
                default: ;
            endcase
        end
        // [RULE12] fresh pointer and count; only the count write rearms a run
        if (wr_go && avs_address == uld_pkg::OFF_PTR) begin
            s_nxt.ptr = merge16(s_r.ptr, avs_writedata, avs_byteenable);
        end
        if (wr_go && avs_address == uld_pkg::OFF_COUNT) begin
            s_nxt.cnt     = merge16(s_r.cnt, avs_writedata, avs_byteenable);
            s_nxt.rx_term = 1'b0;
            s_nxt.tx_term = 1'b0;
        end

        // [RULE16] each rx char triggers a byte
        if (rx_char_valid) begin
            if (rx_run) begin
                s_nxt.rx_pend = 1'b1;
                s_nxt.rx_byte = rx_char;
            end
            // [RULE10] auto-echo queues a resend
            if (s_r.echo_en) begin
                s_nxt.echo_pend = 1'b1;
                s_nxt.echo_byte = rx_char;
            end
        end

        unique case (s_r.st)
            uld_pkg::CH_IDLE: begin
                if (s_r.echo_pend && tx_buf_empty) begin
                    // Echo first so the terminal sees input promptly
                    s_nxt.tx_load   = 1'b1;
                    s_nxt.tx_char   = s_r.echo_byte;
                    s_nxt.echo_pend = rx_char_valid & s_r.echo_en;
                    s_nxt.st        = uld_pkg::CH_SETTLE;
                end else if (s_r.rx_pend && rx_run) begin
                    // [RULE8] deposit into selected memory
                    s_nxt.req    = 1'b1;
                    s_nxt.req_we = 1'b1;
                    s_nxt.st     = uld_pkg::CH_RX_MEM;
                end else if (tx_run && tx_buf_empty) begin
                    // [RULE16] buffer empty fetches the next byte
                    s_nxt.req    = 1'b1;
                    s_nxt.req_we = 1'b0;
                    s_nxt.st     = uld_pkg::CH_TX_MEM;
                end
            end
            uld_pkg::CH_RX_MEM: begin
                if (mp_done) begin
                    s_nxt.rx_pend = rx_char_valid & rx_run;
                    // [RULE15] advance pointer
                    s_nxt.ptr = next_ptr(s_r.ptr, s_r.mem_ext);
                    // [RULE6] count down, finish past zero
                    s_nxt.cnt = s_r.cnt - 16'h0001;
                    if (s_r.cnt == 16'h0000) begin
                        s_nxt.rx_term = 1'b1;
                        s_nxt.rx_pend = 1'b0;
                        // [RULE2] receive completion event
                        s_nxt.evt[uld_pkg::EVT_RX] = 1'b1;
                    end
                    s_nxt.st = uld_pkg::CH_IDLE;
                end
            end
            uld_pkg::CH_TX_MEM: begin
                if (mp_done) begin
                    // [RULE9] byte from memory to transmitter
                    s_nxt.tx_load = 1'b1;
                    s_nxt.tx_char = mp_rdata;
                    // [RULE15] advance pointer
                    s_nxt.ptr = next_ptr(s_r.ptr, s_r.mem_ext);
                    // [RULE6] count down, finish past zero
                    s_nxt.cnt = s_r.cnt - 16'h0001;
                    if (s_r.cnt == 16'h0000) begin
                        s_nxt.tx_term = 1'b1;
                        // [RULE2] transmit completion event
                        s_nxt.evt[uld_pkg::EVT_TX] = 1'b1;
                    end
                    s_nxt.st = uld_pkg::CH_SETTLE;
                end
            end
            uld_pkg::CH_SETTLE: begin
                // Let the transmitter drop its empty flag after a load
                s_nxt.st = uld_pkg::CH_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            s_r         <= '0;
            s_r.ptr     <= uld_pkg::PTR_RST;
            s_r.cnt     <= uld_pkg::CNT_RST;
            s_r.serial_irq_enable_reg     <= uld_pkg::UIE_RST;
            s_r.st      <= uld_pkg::CH_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // [RULE5] pointer pair is the ext address
    uld_mem_port u_mem (
        .mclk      (mclk),
        .resetn    (resetn),
        .req       (s_r.req),
        .req_we    (s_r.req_we),
        .sel_ext   (s_r.mem_ext),
        .addr      (s_r.ptr),
        .wdata     (s_r.rx_byte),
        .done      (mp_done),
        .rdata     (mp_rdata),
        .int_en    (int_en),
        .int_we    (int_we),
        .int_addr  (int_addr),
        .int_wdata (int_wdata),
        .int_rdata (int_rdata),
        .ext_dm_n  (data_memory_select_strobe_n),
        .ext_we    (ext_we),
        .ext_addr  (ext_addr),
        .ext_wdata (ext_wdata),
        .ext_rdata (ext_rdata)
    );

    // [RULE1] serial vector requests
    uld_evt_ctrl u_evt (
        .mclk     (mclk),
        .resetn   (resetn),
        .evt_set  (s_r.evt),
        .clr_we   (clr_we),
        .clr_data (avs_writedata[1:0]),
        .en_we    (en_we),
        .en_data  (avs_writedata[1:0]),
        .vec_en   ({s_r.serial_irq_enable_reg[uld_pkg::BIT_TX_IRQ_EN], s_r.serial_irq_enable_reg[uld_pkg::BIT_RX_IRQ_EN]}),
        .status   (ev_status),
        .enable   (ev_enable),
        .irq      (irq),
        .svc_irq  (svc)
    );

    assign rx_service_irq  = svc[uld_pkg::EVT_RX];
    assign tx_service_irq  = svc[uld_pkg::EVT_TX];
    assign avs_readdata    = s_r.rdata;
    assign avs_waitrequest = ~s_r.wait_n;
    assign tx_load         = s_r.tx_load;
    assign tx_char         = s_r.tx_char;

endmodule : uld_top

// >>> uld_checker.sv
// Checker on uld_top ports.
// Assumes writes land as waitrequest is low.
`timescale 1ns/1ps
module uld_checker (
    input wire logic        mclk,            // Clock
    input wire logic        resetn,          // Reset
    input wire logic [5:0]  avs_address,     // Address
    input wire logic        avs_write,       // Write
    input wire logic [31:0] avs_writedata,   // Write data
    input wire logic [3:0]  avs_byteenable,  // Lanes
    input wire logic        avs_waitrequest, // Stall
    input wire logic        rx_char_valid,   // Char valid
    input wire logic [7:0]  rx_char,         // Char
    input wire logic        tx_load,         // Tx load
    input wire logic [7:0]  tx_char,         // Tx char
    input wire logic        int_en,          // Int strobe
    input wire logic        int_we,          // Int write
    input wire logic        data_memory_select_strobe_n, // Data strobe
    input wire logic        ext_we,          // Ext write
    input wire logic        rx_service_irq,  // Rx vector
    input wire logic        tx_service_irq   // Tx vector
);
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    logic [1:0] mode_r;
    logic [2:0] en_r;
    logic [7:0] last_r;
    wire wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire ext_on = !data_memory_select_strobe_n;

    // Shadow of mode and enable bits
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            mode_r <= 2'h0;
            en_r <= 3'h0;
        end else if (wr_ok && avs_address == uld_pkg::OFF_MEM_CTRL) begin
            mode_r <= avs_writedata[1:0];
        end else if (wr_ok && avs_address == uld_pkg::OFF_IRQ_EN) begin
            en_r <= avs_writedata[2:0];
        end
    end

    // Last char, for the echo match
    always_ff @(posedge mclk) begin
        if (rx_char_valid) begin
            last_r <= rx_char;
        end
    end

    sequence echo_go_s;
        rx_char_valid && mode_r[1];
    endsequence
    sequence echo_out_s;
        ##[1:16] (tx_load && tx_char == last_r);
    endsequence

    strobe_excl_a : assert property (!(int_en && ext_on))
        else $error("both strobes");
    int_sel_a : assert property (int_en |-> !mode_r[0])
        else $error("internal in ext mode");
    ext_sel_a : assert property (ext_on |-> mode_r[0])
        else $error("external in int mode");
    rx_vector_a : assert property ($rose(rx_service_irq) |-> en_r[0])
        else $error("rx vector disabled");
    tx_vector_a : assert property ($rose(tx_service_irq) |-> en_r[2])
        else $error("tx vector disabled");
    rx_link_a : assert property ((int_en && int_we) || (ext_on && ext_we) |-> en_r[1:0] == 2'b11)
        else $error("store without link");
    tx_settle_a : assert property (tx_load |=> !tx_load)
        else $error("tx loads back to back");
    auto_echo_a : assert property (echo_go_s |-> echo_out_s)
        else $error("received char not echoed");
endmodule : uld_checker

bind uld_top uld_checker chk_i (.*);

// >>> uld_far_model.sv
// Far side: both memories and the transmit buffer.
// Assumes reads answer a cycle after the strobe.
`timescale 1ns/1ps
module uld_far_model (
    input  wire logic        mclk,       // Clock
    input  wire logic        int_en,     // Int strobe
    input  wire logic        int_we,     // Int write
    input  wire logic [7:0]  int_addr,   // Int address
    input  wire logic [7:0]  int_wdata,  // Int byte
    output logic      [7:0]  int_rdata,  // Int read
    input  wire logic        data_memory_select_strobe_n, // Data strobe
    input  wire logic        ext_we,     // Ext write
    input  wire logic [15:0] ext_addr,   // Ext address
    input  wire logic [7:0]  ext_wdata,  // Ext byte
    output logic      [7:0]  ext_rdata,  // Ext read
    input  wire logic        tx_load,    // Tx load
    input  wire logic [7:0]  tx_char,    // Tx char
    output logic             tx_buf_empty // Buffer empty
);
    logic [7:0] int_mem [256];
    logic [7:0] ext_mem [65536];
    logic [2:0] busy_r = 3'h0;
    assign tx_buf_empty = (busy_r == 3'h0);
    initial int_rdata = 8'h00;
    initial ext_rdata = 8'h00;

    // Only strobed memory answers, else inverts
    always @(posedge mclk) begin
        int_rdata <= int_en ? int_mem[int_addr] : ~int_rdata;
        ext_rdata <= !data_memory_select_strobe_n ? ext_mem[ext_addr] : ~ext_rdata;
        if (int_en && int_we) int_mem[int_addr] <= int_wdata;
        if (!data_memory_select_strobe_n && ext_we) ext_mem[ext_addr] <= ext_wdata;
    end

    // Busy after a load, length by char parity
    always @(posedge mclk) begin
        if (tx_load) busy_r <= tx_char[0] ? 3'h1 : 3'h6;
        else if (busy_r != 3'h0) busy_r <= busy_r - 3'h1;
    end
endmodule : uld_far_model

// >>> uart_linked_dma_test.sv
// Bench: rx and tx runs to both memories.
// Assumes uld_far_model and the bound checker.
`timescale 1ns/1ps
module uart_linked_dma_test;
    logic mclk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0, rx_char_valid = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [7:0] rx_char = 8'h00;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, tx_load, tx_buf_empty, int_en, int_we, irq;
    logic data_memory_select_strobe_n, ext_we, rx_service_irq, tx_service_irq;
    logic [7:0] tx_char, int_addr, int_wdata, int_rdata, ext_wdata, ext_rdata;
    logic [15:0] ext_addr;
    logic [7:0] txq [$];
    logic [5:0] offs [8] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h1c, 6'h3c};
    int fail_count = 0;
    int check_count = 0;
    int cyc = 0;

    uld_top dut (.*);
    uld_far_model far (.*);

    always #10 mclk = ~mclk;

    // Timeout; log chars sent
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (tx_load === 1'b1) txq.push_back(tx_char);
        if (cyc == 6000) begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    // One Avalon-MM access
    task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= we;
        avs_read <= !we;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    function automatic logic [7:0] get(input logic sel, input logic [15:0] a);
        return sel ? far.ext_mem[a] : far.int_mem[a[7:0]];
    endfunction : get

    task automatic run(input logic tx, input logic sel);
        logic [15:0] base;
        logic [7:0] dat [5];
        int n;
        base = 16'($urandom);
        n = 2 + ($urandom % 3);
        foreach (dat[i]) dat[i] = 8'($urandom);
        bus(1, uld_pkg::OFF_MEM_CTRL, {30'h0, !tx, sel});
        bus(1, uld_pkg::OFF_PTR, {16'h0, base});
        // Count loaded as n minus one
        bus(1, uld_pkg::OFF_COUNT, 32'(n - 1));
        bus(1, uld_pkg::OFF_EVT_EN, 32'h3);
        txq.delete();
        for (int i = 0; i < 5; i++) begin
            if (sel) far.ext_mem[base + 16'(i)] = tx ? dat[i] : 8'h5a;
            else far.int_mem[base[7:0] + 8'(i)] = tx ? dat[i] : 8'h5a;
        end
        if (tx) begin
            bus(1, uld_pkg::OFF_IRQ_EN, 32'h4);
            bus(1, uld_pkg::OFF_TX_CTRL, 32'h1);
        end else begin
            bus(1, uld_pkg::OFF_IRQ_EN, 32'h3);
            for (int i = 0; i <= n; i++) begin
                rx_char_valid <= 1'b1;
                rx_char <= dat[i];
                @(posedge mclk);
                rx_char_valid <= 1'b0;
                repeat (25) @(posedge mclk);
            end
        end
        for (int i = 0; i < 400 && (tx ? tx_service_irq : rx_service_irq) !== 1'b1; i++) @(posedge mclk);
        repeat (20) @(posedge mclk);
        chk(tx ? tx_service_irq : rx_service_irq, 1'b1);
        chk(irq, 1'b1);
        chk(txq.size(), tx ? n : n + 1);
        for (int i = 0; i < n; i++) begin
            chk(txq[i], dat[i]);
            if (!tx) chk(get(sel, base + 16'(i)), dat[i]);
        end
        chk(get(sel, base + 16'(n)), tx ? dat[n] : 8'h5a);
        bus(0, uld_pkg::OFF_COUNT, 0);
        chk(rd, 32'hffff);
        bus(0, uld_pkg::OFF_STATUS, 0);
        chk(rd, tx ? 32'h2 : 32'h1);
        bus(1, uld_pkg::OFF_EVT_EN, 32'h0);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b0);
        bus(1, uld_pkg::OFF_IRQ_EN, 32'h0);
        bus(1, uld_pkg::OFF_TX_CTRL, 32'h0);
        bus(1, uld_pkg::OFF_EVT_CLR, 32'h3);
        bus(0, uld_pkg::OFF_STATUS, 0);
        chk(rd, 32'h0);
        $display("Test done: tx %0d ext %0d bytes %0d", tx, sel, n);
    endtask : run

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    initial begin
        void'($urandom(17685));
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        // Reset values, unmapped word read zero
        foreach (offs[k]) begin
            bus(0, offs[k], 0);
            chk(rd, 32'h0);
        end
        $display("Test done: reset values");
        for (int k = 0; k < 4; k++) run(k[1], k[0]);
        give_verdict();
    end
endmodule : uart_linked_dma_test
